// File: rtl/itu_cmp.sv
// Purpose: one address comparator with an optional tied data comparator
// Assumes: core event bus on the same clock
// Notes: combinational, result used in the cycle of the event
module itu_cmp
#(
  parameter bit HAS_DCMP = 1'b1
)
(
  input  wire itu_pkg::itu_core_t core,
  input  wire logic [31:0]        addr_val,
  input  wire logic               use_daddr,
  input  wire logic               dcmp_en,
  input  wire logic [31:0]        dval,
  input  wire logic [31:0]        dmask,
  output logic                    eq,
  output logic                    ge,
  output logic                    lt,
  output logic                    dmatch
);
  import itu_pkg::*;

  logic [31:0] a;
  logic        v;
  logic        dc_on;

  assign a     = use_daddr ? core.daddr : core.iaddr;
  assign v     = use_daddr ? core.dls : core.exec;
  assign dc_on = HAS_DCMP && dcmp_en;
  // mask bit set means the data bit is ignored
  assign dmatch = dc_on && core.dls && (((core.ddata ^ dval) & ~dmask) == 32'h0);
  assign eq = v && (a == addr_val) && (!dc_on || dmatch);
  assign ge = v && (a >= addr_val);
  assign lt = v && (a < addr_val);
endmodule

// File: rtl/itu_defs.svh
// Purpose: offsets, field positions, reset values and region bounds of the trace unit
// Assumes: included by every trace unit file that needs a number
// Notes: definitions only
`ifndef ITU_DEFS_SVH
`define ITU_DEFS_SVH

`define ITU_FIFO_DEPTH 45
`define ITU_NCMP       4

// register byte offsets, page codes and address bit positions
`define ITU_A_CTRL  8'h00
`define ITU_A_STS   8'h04
`define ITU_A_MASK  8'h08
`define ITU_A_THR   8'h0c
`define ITU_A_SEQ   8'h10
`define ITU_A_TRIG  8'h14
`define ITU_A_STATE 8'h18
`define ITU_PG_AADR 4'h2
`define ITU_PG_ACFG 4'h3
`define ITU_PG_DCMP 4'h4
`define ITU_PG_MSB  7
`define ITU_PG_LSB  4
`define ITU_IX_MSB  3
`define ITU_IX_LSB  2
`define ITU_DC_SEL  2
`define ITU_DC_IX   3

// fields
`define ITU_CTRL_EN   0
`define ITU_CTRL_DTR  1
`define ITU_STS_OVF   0
`define ITU_STS_TRIG  1
`define ITU_CFG_DADDR 0
`define ITU_CFG_RANGE 1
`define ITU_CFG_DCMP  2
`define ITU_SEL_W     5
`define ITU_SEQ_STW   10
`define ITU_TRIG_ANY  2'h3
`define ITU_THR_RST   6'h00

// memory regions
`define ITU_SRAM_LO 32'h0000_0000
`define ITU_SRAM_HI 32'h002f_ffff
`define ITU_ROM_LO  32'h0040_0000
`define ITU_ROM_HI  32'h004f_ffff
`define ITU_EBI_LO  32'h1000_0000
`define ITU_EBI_HI  32'h8fff_ffff
`define ITU_UPER_LO 32'hf000_0000
`define ITU_UPER_HI 32'hffff_bfff
`define ITU_SPER_LO 32'hffff_c000
`define ITU_SPER_HI 32'hffff_ffff

`endif

// File: rtl/itu_pkg.sv
// Purpose: types shared by the trace unit files
// Assumes: nothing
// Notes: core event travels as one packed struct
package itu_pkg;

  typedef struct packed {
    logic        exec;
    logic        cond_fail;
    logic        branch;
    logic [31:0] iaddr;
    logic        dls;
    logic [31:0] daddr;
    logic [31:0] ddata;
  } itu_core_t;

  typedef struct packed {
    logic       sync;
    logic [7:0] data;
  } itu_pkt_t;

  typedef enum logic [2:0] {
    PS_IDLE, PS_EXEC, PS_FAIL, PS_BRANCH, PS_DATA, PS_TRIG, PS_OVFL
  } itu_stat_t;

  typedef enum logic [1:0] {SEQ_S1, SEQ_S2, SEQ_S3} itu_seq_t;

endpackage

// File: rtl/itu_pkt_mem.sv
// Purpose: packet byte store with two write and two read lanes
// Assumes: caller keeps addresses below DEPTH
// Notes: read data registered, one cycle after the address
module itu_pkt_mem
#(
  parameter int DEPTH = 45,
  parameter int AW    = 6
)
(
  input  wire logic              mclk,
  input  wire logic              we0,
  input  wire logic              we1,
  input  wire logic [AW-1:0]     wa0,
  input  wire logic [AW-1:0]     wa1,
  input  wire itu_pkg::itu_pkt_t wd0,
  input  wire itu_pkg::itu_pkt_t wd1,
  input  wire logic [AW-1:0]     ra0,
  input  wire logic [AW-1:0]     ra1,
  output itu_pkg::itu_pkt_t      rd0_q,
  output itu_pkg::itu_pkt_t      rd1_q
);
  import itu_pkg::*;

  // pointers must reach every entry
  if (DEPTH < 2 || AW < $clog2(DEPTH)) begin : g_chk
    $error("itu_pkt_mem: AW too narrow for DEPTH");
  end

  itu_pkt_t mem [DEPTH];

  always_ff @(posedge mclk) begin
    if (we0) begin
      mem[wa0] <= wd0;
    end
    if (we1) begin
      mem[wa1] <= wd1;
    end
  end

  always_ff @(posedge mclk) begin
    rd0_q <= mem[ra0];
    rd1_q <= mem[ra1];
  end
endmodule

// File: rtl/itu_trace.sv
// Purpose: real-time instruction and data trace unit with trigger resources
// Assumes: core event bus and register port on mclk; read data one cycle later
// Notes: trace port updates every mclk, so every trace clock edge carries data
`include "itu_defs.svh"

module itu_trace
#(
  parameter int DEPTH = `ITU_FIFO_DEPTH
)
(
  input  wire logic               mclk,
  input  wire logic               rst_n,
  input  wire itu_pkg::itu_core_t core,
  input  wire logic [7:0]         reg_addr,
  input  wire logic [31:0]        reg_wdata,
  input  wire logic               reg_wr,
  input  wire logic               reg_rd,
  output logic [31:0]             reg_rdata,
  output logic                    irq,
  output logic                    trace_port_clock,
  output logic [2:0]              pipeline_status_code,
  output logic [15:0]             packet_bus,
  output logic                    branch_sync_strobe
);
  import itu_pkg::*;

  localparam int AW = $clog2(DEPTH);
  localparam int CW = $clog2(DEPTH + 1);
  localparam int NC = `ITU_NCMP;

  if (DEPTH < 4 || DEPTH > 63) begin : g_chk
    $error("itu_trace: DEPTH must lie between 4 and 63");
  end

  // software state
  logic [1:0]  ctrl_q;
  logic [1:0]  sts_q;
  logic [1:0]  mask_q;
  logic [5:0]  thr_q;
  logic [29:0] seq_cfg_q;
  logic [6:0]  trig_q;
  logic [31:0] acmp_addr_q [NC];
  logic [2:0]  acmp_cfg_q  [NC];
  logic [31:0] dval_q      [2];
  logic [31:0] dmask_q     [2];

  // fifo state
  logic [AW-1:0] wptr_q;
  logic [AW-1:0] rptr_q;
  logic [CW-1:0] cnt_q;
  logic [1:0]    pop_q;
  logic [1:0]    pop_n;
  logic [6:0]    free;
  itu_pkt_t      wd0;
  itu_pkt_t      wd1;
  itu_pkt_t      rd0_q;
  itu_pkt_t      rd1_q;
  logic          want;
  logic          ovf;
  logic          push;

  // trigger state
  logic [NC-1:0] c_eq;
  logic [NC-1:0] c_ge;
  logic [NC-1:0] c_lt;
  logic [NC-1:0] c_dm;
  logic [NC-1:0] a_hit;
  logic [15:0]   ev;
  itu_seq_t      seq_q;
  logic [1:0]    seq_n;
  logic [4:0]    seq_fwd;
  logic [4:0]    seq_alt;
  logic          trig_hit;
  itu_stat_t     st;
  itu_stat_t     st_a_q;
  logic [31:0]   rmux;
  logic [3:0]    page;
  logic [1:0]    idx;

  function automatic logic in_rng(input logic [31:0] a, input logic [31:0] lo,
                                  input logic [31:0] hi);
    return (a >= lo) && (a <= hi);
  endfunction

  function automatic logic ev_pick(input logic [15:0] e, input logic [4:0] sel);
    return sel[`ITU_SEL_W-1] && e[sel[`ITU_SEL_W-2:0]];
  endfunction

  function automatic logic [AW-1:0] ptr_add(input logic [AW-1:0] p, input logic [1:0] n);
    logic [AW:0] s;
    s = {1'b0, p} + (AW+1)'(n);
    return (s >= (AW+1)'(DEPTH)) ? AW'(s - (AW+1)'(DEPTH)) : AW'(s);
  endfunction

  function automatic logic [7:0] regions(input itu_core_t c);
    logic [7:0] r;
    r[0] = c.dls  && in_rng(c.daddr, `ITU_SRAM_LO, `ITU_SRAM_HI);
    r[1] = c.exec && in_rng(c.iaddr, `ITU_SRAM_LO, `ITU_SRAM_HI);
    r[2] = c.dls  && in_rng(c.daddr, `ITU_ROM_LO, `ITU_ROM_HI);
    r[3] = c.exec && in_rng(c.iaddr, `ITU_ROM_LO, `ITU_ROM_HI);
    r[4] = c.dls  && in_rng(c.daddr, `ITU_EBI_LO, `ITU_EBI_HI);
    r[5] = c.exec && in_rng(c.iaddr, `ITU_EBI_LO, `ITU_EBI_HI);
    r[6] = c.dls  && in_rng(c.daddr, `ITU_UPER_LO, `ITU_UPER_HI);
    r[7] = c.dls  && in_rng(c.daddr, `ITU_SPER_LO, `ITU_SPER_HI);
    return r;
  endfunction

  function automatic itu_seq_t seq_step(input itu_seq_t s, input logic alt);
    case (s)
      SEQ_S1:  return alt ? SEQ_S3 : SEQ_S2;
      SEQ_S2:  return alt ? SEQ_S1 : SEQ_S3;
      SEQ_S3:  return alt ? SEQ_S2 : SEQ_S1;
      default: return SEQ_S1;
    endcase
  endfunction

  // ---------------- comparators ----------------
  for (genvar i = 0; i < NC; i++) begin : g_cmp
    itu_cmp #(
      .HAS_DCMP (i % 2 == 0)
    ) u_cmp (
      .core      (core),
      .addr_val  (acmp_addr_q[i]),
      .use_daddr (acmp_cfg_q[i][`ITU_CFG_DADDR]),
      .dcmp_en   (acmp_cfg_q[i][`ITU_CFG_DCMP]),
      .dval      (dval_q[i/2]),
      .dmask     (dmask_q[i/2]),
      .eq        (c_eq[i]),
      .ge        (c_ge[i]),
      .lt        (c_lt[i]),
      .dmatch    (c_dm[i])
    );
  end

  // range mode trusts both halves of a pair to share mode and access type
  always_comb begin
    for (int p = 0; p < NC / 2; p++) begin
      if (acmp_cfg_q[2*p][`ITU_CFG_RANGE]) begin
        a_hit[2*p]   = c_ge[2*p] && c_lt[2*p+1];
        a_hit[2*p+1] = c_ge[2*p] && c_lt[2*p+1];
      end else begin
        a_hit[2*p]   = c_eq[2*p];
        a_hit[2*p+1] = c_eq[2*p+1];
      end
    end
  end

  // no external event inputs feed the event vector
  assign ev = {core.branch, 1'b1, regions(core), c_dm[2], c_dm[0], a_hit};

  // ---------------- sequencer and trigger ----------------
  always_comb begin
    case (seq_q)
      SEQ_S1:  seq_n = 2'h0;
      SEQ_S2:  seq_n = 2'h1;
      SEQ_S3:  seq_n = 2'h2;
      default: seq_n = 2'h0;
    endcase
  end

  assign seq_fwd = seq_cfg_q[int'(seq_n) * `ITU_SEQ_STW +: `ITU_SEL_W];
  assign seq_alt = seq_cfg_q[int'(seq_n) * `ITU_SEQ_STW + `ITU_SEL_W +: `ITU_SEL_W];

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      seq_q <= SEQ_S1;
    end else if (ev_pick(ev, seq_fwd)) begin
      seq_q <= seq_step(seq_q, 1'b0);
    end else if (ev_pick(ev, seq_alt)) begin
      seq_q <= seq_step(seq_q, 1'b1);
    end
  end

  assign trig_hit = ev_pick(ev, trig_q[4:0]) &&
                    (trig_q[6:5] == `ITU_TRIG_ANY || trig_q[6:5] == seq_n);

  // ---------------- packet source ----------------
  always_comb begin
    want = 1'b0;
    st   = PS_IDLE;
    wd0  = '0;
    wd1  = '0;
    if (ctrl_q[`ITU_CTRL_EN]) begin
      if (core.exec && core.branch && !core.cond_fail) begin
        want = 1'b1;
        st   = PS_BRANCH;
        wd0  = '{sync: 1'b1, data: core.iaddr[7:0]};
        wd1  = '{sync: 1'b0, data: core.iaddr[15:8]};
      end else if (core.dls && ctrl_q[`ITU_CTRL_DTR]) begin
        want = 1'b1;
        st   = PS_DATA;
        wd0  = '{sync: 1'b0, data: core.ddata[7:0]};
        wd1  = '{sync: 1'b0, data: core.ddata[15:8]};
      end else if (trig_hit) begin
        st = PS_TRIG;
      end else if (core.exec && core.cond_fail) begin
        st = PS_FAIL;
      end else if (core.exec) begin
        st = PS_EXEC;
      end
    end
    if (ovf) begin
      st = PS_OVFL;
    end
  end

  // ---------------- packet fifo ----------------
  assign free  = 7'(DEPTH) - 7'(cnt_q);
  assign ovf   = want && (free < 7'h02 || free < {1'b0, thr_q});
  assign push  = want && !ovf;
  assign pop_n = (cnt_q >= CW'(2)) ? 2'h2 : ((cnt_q != '0) ? 2'h1 : 2'h0);

  itu_pkt_mem #(
    .DEPTH (DEPTH),
    .AW    (AW)
  ) u_mem (
    .mclk  (mclk),
    .we0   (push),
    .we1   (push),
    .wa0   (wptr_q),
    .wa1   (ptr_add(wptr_q, 2'h1)),
    .wd0   (wd0),
    .wd1   (wd1),
    .ra0   (rptr_q),
    .ra1   (ptr_add(rptr_q, 2'h1)),
    .rd0_q (rd0_q),
    .rd1_q (rd1_q)
  );

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      wptr_q <= '0;
      rptr_q <= '0;
      cnt_q  <= '0;
      pop_q  <= 2'h0;
    end else begin
      if (push) begin
        wptr_q <= ptr_add(wptr_q, 2'h2);
      end
      rptr_q <= ptr_add(rptr_q, pop_n);
      cnt_q  <= cnt_q + (push ? CW'(2) : CW'(0)) - CW'(pop_n);
      pop_q  <= pop_n;
    end
  end

  // ---------------- trace port ----------------
  // toggles every mclk: half rate, and each mclk is one trace clock edge
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      trace_port_clock <= 1'b0;
    end else begin
      trace_port_clock <= ~trace_port_clock;
    end
  end

  // status delayed two stages so it leaves beside the fifo read stage
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      st_a_q               <= PS_IDLE;
      pipeline_status_code <= 3'h0;
    end else begin
      st_a_q               <= st;
      pipeline_status_code <= st_a_q;
    end
  end

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      packet_bus         <= 16'h0000;
      branch_sync_strobe <= 1'b0;
    end else begin
      packet_bus[7:0]    <= (pop_q != 2'h0) ? rd0_q.data : 8'h00;
      packet_bus[15:8]   <= (pop_q == 2'h2) ? rd1_q.data : 8'h00;
      branch_sync_strobe <= ((pop_q != 2'h0) && rd0_q.sync) ||
                            ((pop_q == 2'h2) && rd1_q.sync);
    end
  end

  // ---------------- registers ----------------
  assign page = reg_addr[`ITU_PG_MSB:`ITU_PG_LSB];
  assign idx  = reg_addr[`ITU_IX_MSB:`ITU_IX_LSB];

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      ctrl_q    <= 2'h0;
      mask_q    <= 2'h0;
      thr_q     <= `ITU_THR_RST;
      seq_cfg_q <= 30'h0;
      trig_q    <= 7'h00;
    end else if (reg_wr) begin
      case (reg_addr)
        `ITU_A_CTRL: ctrl_q    <= reg_wdata[1:0];
        `ITU_A_MASK: mask_q    <= reg_wdata[1:0];
        `ITU_A_THR:  thr_q     <= reg_wdata[5:0];
        `ITU_A_SEQ:  seq_cfg_q <= reg_wdata[29:0];
        `ITU_A_TRIG: trig_q    <= reg_wdata[6:0];
        default: ;
      endcase
    end
  end

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      for (int i = 0; i < NC; i++) begin
        acmp_addr_q[i] <= 32'h0;
        acmp_cfg_q[i]  <= 3'h0;
      end
      for (int i = 0; i < 2; i++) begin
        dval_q[i]  <= 32'h0;
        dmask_q[i] <= 32'h0;
      end
    end else if (reg_wr && reg_addr[1:0] == 2'h0) begin
      if (page == `ITU_PG_AADR) begin
        acmp_addr_q[idx] <= reg_wdata;
      end else if (page == `ITU_PG_ACFG) begin
        acmp_cfg_q[idx] <= reg_wdata[2:0];
      end else if (page == `ITU_PG_DCMP && !reg_addr[`ITU_DC_SEL]) begin
        dval_q[reg_addr[`ITU_DC_IX]] <= reg_wdata;
      end else if (page == `ITU_PG_DCMP) begin
        dmask_q[reg_addr[`ITU_DC_IX]] <= reg_wdata;
      end
    end
  end

  // set wins over a write-one clear in the same cycle
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      sts_q <= 2'h0;
      irq   <= 1'b0;
    end else begin
      sts_q <= (sts_q & ~((reg_wr && reg_addr == `ITU_A_STS) ? reg_wdata[1:0] : 2'h0))
               | {trig_hit, ovf};
      irq   <= |(sts_q & mask_q);
    end
  end

  always_comb begin
    rmux = 32'h0;
    case (reg_addr)
      `ITU_A_CTRL:  rmux = 32'(ctrl_q);
      `ITU_A_STS:   rmux = 32'(sts_q);
      `ITU_A_MASK:  rmux = 32'(mask_q);
      `ITU_A_THR:   rmux = 32'(thr_q);
      `ITU_A_SEQ:   rmux = 32'(seq_cfg_q);
      `ITU_A_TRIG:  rmux = 32'(trig_q);
      `ITU_A_STATE: rmux = 32'({8'(cnt_q), 6'h0, seq_n});
      default: begin
        if (reg_addr[1:0] != 2'h0) begin
          rmux = 32'h0;
        end else if (page == `ITU_PG_AADR) begin
          rmux = acmp_addr_q[idx];
        end else if (page == `ITU_PG_ACFG) begin
          rmux = 32'(acmp_cfg_q[idx]);
        end else if (page == `ITU_PG_DCMP && !reg_addr[`ITU_DC_SEL]) begin
          rmux = dval_q[reg_addr[`ITU_DC_IX]];
        end else if (page == `ITU_PG_DCMP) begin
          rmux = dmask_q[reg_addr[`ITU_DC_IX]];
        end
      end
    endcase
  end

  // read data stands for one cycle per cycle of reg_rd, zero otherwise
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      reg_rdata <= 32'h0;
    end else begin
      reg_rdata <= reg_rd ? rmux : 32'h0;
    end
  end
endmodule

// File: verif/itu_cap.sv
// Purpose: trace capture analyzer model
// Assumes: trace clock made by the unit, seen from mclk
// Notes: a zero byte reads as no byte, so tests avoid zero data
module itu_cap
(
  input wire logic        mclk,
  input wire logic        rst_n,
  input wire logic        trace_port_clock,
  input wire logic [2:0]  pipeline_status_code,
  input wire logic [15:0] packet_bus,
  input wire logic        branch_sync_strobe
);
  timeunit 1ns;
  timeprecision 1ps;
  logic       last;
  logic [2:0] sq[$];
  logic [7:0] bq[$];
  logic [7:0] sb[$];
  // half-rate capture: take data on either trace clock edge
  always @(posedge mclk) begin
    if (!rst_n) begin
      last = 1'b0;
    end else if (trace_port_clock !== last) begin
      last = trace_port_clock;
      if (pipeline_status_code != 3'h0) sq.push_back(pipeline_status_code);
      if (branch_sync_strobe) sb.push_back(packet_bus[7:0]);
      if (packet_bus[7:0] != 8'h0) bq.push_back(packet_bus[7:0]);
      if (packet_bus[15:8] != 8'h0) bq.push_back(packet_bus[15:8]);
    end
  end
endmodule

// File: verif/itu_sva.sv
// Purpose: port checks for itu_trace
// Assumes: bound to the top module
// Notes: shadows ctrl, mask and thr writes
`include "itu_defs.svh"
module itu_sva
(
  input wire logic               mclk,
  input wire logic               rst_n,
  input wire itu_pkg::itu_core_t core,
  input wire logic [7:0]         reg_addr,
  input wire logic [31:0]        reg_wdata,
  input wire logic               reg_wr,
  input wire logic               reg_rd,
  input wire logic [31:0]        reg_rdata,
  input wire logic               irq,
  input wire logic               trace_port_clock,
  input wire logic [2:0]         pipeline_status_code,
  input wire logic [15:0]        packet_bus,
  input wire logic               branch_sync_strobe
);
  timeunit 1ns;
  timeprecision 1ps;
  import itu_pkg::*;
  logic       en_q, den_q, msk_q, br, dt;
  logic [5:0] thr_q;
  logic [4:0] q_q;
  assign br = en_q & core.exec & core.branch & ~core.cond_fail;
  assign dt = en_q & den_q & core.dls;
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      {en_q, den_q, msk_q, thr_q} <= '0;
    end else if (reg_wr) begin
      if (reg_addr == `ITU_A_CTRL) {den_q, en_q} <= reg_wdata[1:0];
      if (reg_addr == `ITU_A_MASK) msk_q <= reg_wdata[0];
      if (reg_addr == `ITU_A_THR) thr_q <= reg_wdata[5:0];
    end
  end
  // idle cycles since the last branch or data event; 31 covers a full drain
  always_ff @(posedge mclk) begin
    if (!rst_n || br || dt) begin
      q_q <= '0;
    end else if (q_q != 5'h1f) begin
      q_q <= q_q + 5'h1;
    end
  end
  default clocking @(posedge mclk); endclocking
  default disable iff (!rst_n);
  a_clk_toggle: assert property (
    $past(rst_n, 2) |-> trace_port_clock != $past(trace_port_clock))
    else $error("trace clock stuck");
  a_clk_reset: assert property (disable iff (1'b0)
    !rst_n |=> !trace_port_clock) else $error("trace clock not cleared");
  a_branch_code: assert property (
    br |-> ##2 pipeline_status_code inside {PS_BRANCH, PS_OVFL})
    else $error("branch code missing");
  a_fail_status: assert property (
    en_q && core.exec && core.cond_fail && !dt |->
    ##2 pipeline_status_code inside {PS_FAIL, PS_TRIG}) else $error("fail code missing");
  a_sync_after: assert property (
    br ##2 pipeline_status_code == PS_BRANCH |-> ##[1:30] branch_sync_strobe)
    else $error("sync strobe missing");
  a_bus_quiet: assert property (
    q_q == 5'h1f |-> packet_bus == 16'h0 && !branch_sync_strobe)
    else $error("bytes with no push");
  a_thr_refuse: assert property (
    (br || dt) && thr_q == 6'h3f |-> ##2 pipeline_status_code == PS_OVFL)
    else $error("threshold overflow missed");
  a_irq_masked: assert property (
    !$past(msk_q) |-> !irq) else $error("masked irq high");
  c_branch: cover property (br ##2 pipeline_status_code == PS_BRANCH);
  c_sync: cover property (branch_sync_strobe);
  c_ovfl: cover property (pipeline_status_code == PS_OVFL ##[1:3] irq);
endmodule
bind itu_trace itu_sva u_sva (.mclk, .rst_n, .core, .reg_addr, .reg_wdata, .reg_wr,
  .reg_rd, .reg_rdata, .irq, .trace_port_clock, .pipeline_status_code, .packet_bus,
  .branch_sync_strobe);

// File: verif/itu_trace_tb.sv
// Purpose: self-checking bench for itu_trace
// Assumes: itu_cap watches the trace port
// Notes: core events last one cycle each
`include "itu_defs.svh"
module itu_trace_tb;
  timeunit 1ns;
  timeprecision 1ps;
  import itu_pkg::*;
  logic        mclk, rst_n, reg_wr, reg_rd, irq;
  logic        trace_port_clock, branch_sync_strobe;
  logic [2:0]  pipeline_status_code;
  logic [7:0]  reg_addr;
  logic [15:0] packet_bus;
  logic [31:0] reg_wdata, reg_rdata, v;
  itu_core_t   core, c;
  int          miscompares, comparisons;

  itu_trace uut (.mclk, .rst_n, .core, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
    .reg_rdata, .irq, .trace_port_clock, .pipeline_status_code, .packet_bus,
    .branch_sync_strobe);
  itu_cap cap (.mclk, .rst_n, .trace_port_clock, .pipeline_status_code, .packet_bus,
    .branch_sync_strobe);

  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end

  task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
    comparisons++;
    if (s !== e) begin
      miscompares++;
      $display("unexpected %s: expected %h, seen %h", n, e, s);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge mclk);
    reg_wr    <= 1'b1;
    reg_addr  <= a;
    reg_wdata <= d;
    @(posedge mclk);
    reg_wr <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a);
    @(posedge mclk);
    reg_rd   <= 1'b1;
    reg_addr <= a;
    @(posedge mclk);
    reg_rd <= 1'b0;
    #1 v = reg_rdata;
  endtask

  function automatic itu_core_t fe(input logic [31:0] a);
    fe       = '0;
    fe.exec  = 1'b1;
    fe.iaddr = a;
  endfunction

  function automatic itu_core_t dl(input logic [31:0] a, input logic [31:0] d);
    dl       = '0;
    dl.dls   = 1'b1;
    dl.daddr = a;
    dl.ddata = d;
  endfunction

  task automatic ev(input itu_core_t e);
    @(posedge mclk);
    core <= e;
    @(posedge mclk);
    core <= '0;
  endtask

  // one event against one trigger select, then the sticky bit
  task automatic tc(input logic [3:0] i, input itu_core_t e, input int x);
    wr(`ITU_A_TRIG, {25'h0, `ITU_TRIG_ANY, 1'b1, i});
    wr(`ITU_A_STS, 32'h2);
    ev(e);
    repeat (2) @(posedge mclk);
    rd(`ITU_A_STS);
    chk("trigger", 32'(v[1]), 32'(x));
  endtask

  task automatic results;
    $display("checks %0d mismatches %0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  task automatic t_trace;
    logic [2:0] es [4] = '{PS_BRANCH, PS_DATA, PS_FAIL, PS_EXEC};
    logic [7:0] eb [4] = '{8'h3c, 8'h5a, 8'h11, 8'h7e};
    c        = fe(32'h5a3c);
    c.branch = 1'b1;
    wr(`ITU_A_CTRL, 32'h3);
    @(posedge mclk);
    core <= c;
    @(posedge mclk);
    core <= dl(32'h0, 32'h7e11);
    c.branch    = 1'b0;
    c.cond_fail = 1'b1;
    @(posedge mclk);
    core <= c;
    @(posedge mclk);
    core <= fe(32'h40);
    @(posedge mclk);
    core <= '0;
    repeat (40) @(posedge mclk);
    chk("codes", 32'(cap.sq.size()), 32'h4);
    chk("bytes", 32'(cap.bq.size()), 32'h4);
    for (int i = 0; i < 4; i++) begin
      chk("code", 32'(cap.sq[i]), 32'(es[i]));
      chk("byte", 32'(cap.bq[i]), 32'(eb[i]));
    end
    chk("sync byte", 32'(cap.sb[0]), 32'h3c);
    chk("syncs", 32'(cap.sb.size()), 32'h1);
    $display("trace test done");
  endtask

  task automatic t_ovf;
    cap.sq.delete();
    cap.bq.delete();
    wr(`ITU_A_THR, 32'h3f);
    wr(`ITU_A_MASK, 32'h1);
    c        = fe(32'h1234);
    c.branch = 1'b1;
    ev(c);
    repeat (6) @(posedge mclk);
    chk("irq", 32'(irq), 32'h1);
    chk("code", 32'(cap.sq[0]), 32'(PS_OVFL));
    chk("bytes", 32'(cap.bq.size()), 32'h0);
    // threshold one below the empty free space: second event is refused
    cap.sq.delete();
    cap.bq.delete();
    wr(`ITU_A_THR, 32'h2c);
    @(posedge mclk);
    core <= c;
    @(posedge mclk);
    c.iaddr = 32'h5678;
    core    <= c;
    @(posedge mclk);
    core <= '0;
    repeat (6) @(posedge mclk);
    chk("threshold code", 32'(cap.sq[0]), 32'(PS_BRANCH));
    chk("threshold code", 32'(cap.sq[1]), 32'(PS_OVFL));
    chk("threshold bytes", 32'(cap.bq.size()), 32'h2);
    rd(`ITU_A_STS);
    chk("status", v, 32'h1);
    wr(`ITU_A_MASK, 32'h0);
    repeat (2) @(posedge mclk);
    chk("masked irq", 32'(irq), 32'h0);
    wr(`ITU_A_MASK, 32'h1);
    wr(`ITU_A_STS, 32'h1);
    repeat (2) @(posedge mclk);
    chk("cleared irq", 32'(irq), 32'h0);
    rd(`ITU_A_STS);
    chk("status", v, 32'h0);
    wr(`ITU_A_THR, 32'h0);
    $display("overflow test done");
  endtask

  task automatic t_trig;
    wr(`ITU_A_CTRL, 32'h1);
    wr(8'h20, 32'h100);
    wr(8'h24, 32'h200);
    wr(8'h34, 32'h1);
    wr(8'h28, 32'h1000);
    wr(8'h2c, 32'h2000);
    wr(8'h38, 32'h2);
    wr(8'h3c, 32'h2);
    wr(8'h40, 32'hab00);
    wr(8'h44, 32'hffff_00ff);
    tc(4'h0, fe(32'h100), 1);
    tc(4'h0, fe(32'h104), 0);
    tc(4'h1, dl(32'h200, 32'h1), 1);
    tc(4'h1, fe(32'h200), 0);
    tc(4'h2, fe(32'h1000), 1);
    tc(4'h2, fe(32'h1fff), 1);
    tc(4'h2, fe(32'h2000), 0);
    tc(4'h6, dl(32'h002f_ffff, 32'h1), 1);
    tc(4'h7, fe(32'h0030_0000), 0);
    tc(4'h9, fe(32'h004f_ffff), 1);
    tc(4'ha, dl(32'h8fff_ffff, 32'h1), 1);
    tc(4'hb, fe(32'h0fff_ffff), 0);
    tc(4'hc, dl(32'hffff_c000, 32'h1), 0);
    tc(4'hd, dl(32'hffff_c000, 32'h1), 1);
    tc(4'hd, fe(32'hffff_c000), 0);
    wr(8'h30, 32'h5);
    tc(4'h4, dl(32'h100, 32'h1234_abcd), 1);
    tc(4'h4, dl(32'h100, 32'h1234_accd), 0);
    tc(4'h4, fe(32'h100), 0);
    $display("trigger test done");
  endtask

  task automatic t_seq;
    wr(`ITU_A_TRIG, 32'h0);
    wr(`ITU_A_SEQ, 32'h1e);
    rd(`ITU_A_STATE);
    chk("state", v, 32'h1);
    // read data must fall back to zero one cycle later
    @(posedge mclk);
    #1 chk("read stands", reg_rdata, 32'h0);
    wr(`ITU_A_SEQ, 32'h1e << 15);
    rd(`ITU_A_STATE);
    chk("state", v, 32'h0);
    wr(`ITU_A_SEQ, 32'h1e << 5);
    rd(`ITU_A_STATE);
    chk("state", v, 32'h2);
    wr(`ITU_A_TRIG, 32'h3e);
    wr(`ITU_A_STS, 32'h2);
    rd(`ITU_A_STS);
    chk("state trigger", v, 32'h0);
    wr(`ITU_A_TRIG, 32'h5e);
    rd(`ITU_A_STS);
    chk("state trigger", v, 32'h2);
    wr(`ITU_A_SEQ, 32'h1e << 20);
    rd(`ITU_A_STATE);
    chk("state", v, 32'h0);
    $display("sequencer test done");
  endtask

  initial begin
    rst_n     = 1'b0;
    reg_wr    = 1'b0;
    reg_rd    = 1'b0;
    reg_addr  = 8'h0;
    reg_wdata = 32'h0;
    core      = '0;
    repeat (20) @(posedge mclk);
    chk("reset clock", 32'(trace_port_clock), 32'h0);
    rst_n <= 1'b1;
    for (int a = 0; a <= 'h1c; a += 4) begin
      rd(8'(a));
      chk("reset value", v, 32'h0);
    end
    wr(`ITU_A_STATE, 32'h3);
    rd(`ITU_A_STATE);
    chk("read only", v, 32'h0);
    $display("reset test done");
    t_trace();
    t_ovf();
    t_trig();
    t_seq();
    results();
  end

  initial begin
    #100us;
    miscompares++;
    results();
  end
endmodule
